// *** design/meter_ctrl_map.vh ***
`ifndef METER_CTRL_MAP_VH
`define METER_CTRL_MAP_VH

`define MC_CLK_HZ        100000000
`define MC_MS_PER_S      1000
`define MC_S_PER_MIN     60
`define MC_MIN_PER_H     60

// timing, each in its own unit
`define MC_DISP_OFF_MIN  8
`define MC_HEARTBEAT_S   30
`define MC_ADAPT_MAX_S   7'h40
`define MC_ADAPT_MIN_S   7'h04
`define MC_NORMAL_S      7'h20
`define MC_FAST_S        7'h04
`define MC_LEAK_WIN_H    24
`define MC_LEAK_SUB1_MIN 8'h1E
`define MC_LEAK_SUB2_MIN 8'h3C
`define MC_LEAK_SUB3_MIN 8'h78
`define MC_PW_32_MS      32
`define MC_PW_100_MS     100

// pulse width codes
`define MC_PW_CODE_32    7'h5F
`define MC_PW_CODE_100   7'h60

// register word addresses
`define MC_ADDR_CTRL     4'h0
`define MC_ADDR_PULSE    4'h1
`define MC_ADDR_THRESH   4'h2
`define MC_ADDR_STATUS   4'h3

// control fields and reset values
`define MC_CTRL_MODE_LSB 0
`define MC_CTRL_LEAK_LSB 3
`define MC_CTRL_LEAKB    5
`define MC_PULSE_RES_LSB 8
`define MC_MODE_RESET    3'h1
`define MC_LEAK_RESET    2'h2
`define MC_THRESH_RESET  16'h0010
`define MC_RES_RESET     2'h0

`endif

// *** design/meter_integration_leak_pulse_ctrl.v ***
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "meter_ctrl_map.vh"

module meter_integration_leak_pulse_ctrl #(
    parameter METER_TYPE   = 1,
    parameter CLKS_PER_SEC = `MC_CLK_HZ,
    parameter CLKS_PER_MS  = `MC_CLK_HZ / `MC_MS_PER_S
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWrStrobe,
    input  wire        regRdStrobe,
    output wire [31:0] regRdData,
    input  wire        keyPress,
    input  wire        sampleValid,
    input  wire [15:0] flowSample,
    input  wire [15:0] powerSample,
    input  wire        pulseInA,
    input  wire        pulseInB,
    input  wire        heatEnergyInc,
    input  wire        coolingEnergyInc,
    input  wire        volumeInc,
    output wire        integrateStrobe,
    output wire        displayOn,
    output wire        heartbeatDot,
    output wire        leakAlarm,
    output wire        pulseOutC,
    output wire        pulseOutD
);

    localparam DISP_OFF_S = `MC_DISP_OFF_MIN * `MC_S_PER_MIN;
    localparam [10:0] LEAK_WIN_MIN = `MC_LEAK_WIN_H * `MC_MIN_PER_H;
    localparam SRC_HEAT = 2'd0;
    localparam SRC_COOL = 2'd1;
    localparam SRC_VOL  = 2'd2;
    localparam PG_IDLE  = 2'd0;
    localparam PG_HIGH  = 2'd1;
    localparam PG_GAP   = 2'd2;

    // ****************************************
    // helper functions
    // ****************************************
    function [15:0] absDiff;
        input [15:0] a;
        input [15:0] b;
        begin
            absDiff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    function [1:0] routeSource;
        input integer mtype;
        input integer outIdx;
        begin
            case (mtype)
                3, 6: routeSource = (outIdx == 0) ? SRC_HEAT : SRC_COOL;
                5: routeSource = (outIdx == 0) ? SRC_COOL : SRC_VOL;
                7, 8: routeSource = SRC_VOL;
                default: routeSource = (outIdx == 0) ? SRC_HEAT : SRC_VOL;
            endcase
        end
    endfunction

    function [31:0] pulseCycles;
        input [6:0] code;
        begin
            case (code)
                `MC_PW_CODE_100: pulseCycles = `MC_PW_100_MS * CLKS_PER_MS;
                default: pulseCycles = `MC_PW_32_MS * CLKS_PER_MS;
            endcase
        end
    endfunction

    function [7:0] leakSubMinutes;
        input [1:0] code;
        begin
            case (code)
                2'd1: leakSubMinutes = `MC_LEAK_SUB1_MIN;
                2'd3: leakSubMinutes = `MC_LEAK_SUB3_MIN;
                default: leakSubMinutes = `MC_LEAK_SUB2_MIN;
            endcase
        end
    endfunction

    // ****************************************
    // register file
    // ****************************************
    reg [2:0]  modeCode_reg;
    reg [1:0]  leakCode_reg;
    reg        leakOnB_reg;
    reg [6:0]  pulseWidthCode_reg;
    reg [1:0]  resCode_reg;
    reg [15:0] threshold_reg;
    reg [31:0] rdData_reg;
    reg [6:0]  interval_reg;
    reg        displayOn_reg;
    reg        leak_reg;
    reg [5:0]  streak_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            modeCode_reg       <= `MC_MODE_RESET;
            leakCode_reg       <= `MC_LEAK_RESET;
            leakOnB_reg        <= 1'b0;
            pulseWidthCode_reg <= `MC_PW_CODE_32;
            resCode_reg        <= `MC_RES_RESET;
            threshold_reg      <= `MC_THRESH_RESET;
        end else if (regWrStrobe) begin
            case (regAddr)
                `MC_ADDR_CTRL: begin
                    modeCode_reg <= regWrData[`MC_CTRL_MODE_LSB +: 3];
                    leakCode_reg <= regWrData[`MC_CTRL_LEAK_LSB +: 2];
                    leakOnB_reg  <= regWrData[`MC_CTRL_LEAKB];
                end
                `MC_ADDR_PULSE: begin
                    pulseWidthCode_reg <= regWrData[6:0];
                    resCode_reg        <= regWrData[`MC_PULSE_RES_LSB +: 2];
                end
                `MC_ADDR_THRESH: threshold_reg <= regWrData[15:0];
                default: ;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (rst)
            rdData_reg <= 32'h0000_0000;
        else if (regRdStrobe) begin
            case (regAddr)
                `MC_ADDR_CTRL:
                    rdData_reg <= {26'h000_0000, leakOnB_reg, leakCode_reg, modeCode_reg};
                `MC_ADDR_PULSE:
                    rdData_reg <= {22'h00_0000, resCode_reg, 1'b0, pulseWidthCode_reg};
                `MC_ADDR_THRESH: rdData_reg <= {16'h0000, threshold_reg};
                `MC_ADDR_STATUS:
                    rdData_reg <= {16'h0000, streak_reg, leak_reg, displayOn_reg, 1'b0,
                                   interval_reg};
                default: rdData_reg <= 32'h0000_0000;
            endcase
        end else
            rdData_reg <= 32'h0000_0000;
    end

    assign regRdData = rdData_reg;

    // ****************************************
    // second and minute timebase
    // ****************************************
    reg [31:0] secCnt_reg;
    reg        secTick;
    reg [5:0]  minCnt_reg;
    reg        minTick;

    always @(posedge sys_clk) begin
        if (rst) begin
            secCnt_reg <= 32'h0000_0000;
            secTick    <= 1'b0;
            minCnt_reg <= 6'h00;
            minTick    <= 1'b0;
        end else begin
            secTick <= (secCnt_reg == CLKS_PER_SEC - 1);
            secCnt_reg <= (secCnt_reg == CLKS_PER_SEC - 1) ? 32'h0000_0000 : secCnt_reg + 1;
            minTick <= secTick && (minCnt_reg == `MC_S_PER_MIN - 1);
            if (secTick)
                minCnt_reg <= (minCnt_reg == `MC_S_PER_MIN - 1) ? 6'h00 : minCnt_reg + 6'h01;
        end
    end

    // ****************************************
    // integration scheduler
    // ****************************************
    reg [15:0] prevFlow_reg;
    reg [15:0] prevPower_reg;
    reg        havePrev_reg;
    reg [6:0]  intCnt_reg;
    reg        integrate_reg;
    wire [1:0] modeSel = modeCode_reg[1:0];
    wire       adaptive = (modeSel == 2'd1);
    wire       changeNow = sampleValid && havePrev_reg &&
                           ((absDiff(flowSample, prevFlow_reg) > threshold_reg) ||
                            (absDiff(powerSample, prevPower_reg) > threshold_reg));
    reg        changeSeen_reg;
    wire       intervalEnd = secTick && (intCnt_reg + 7'd1 >= interval_reg);

    always @(posedge sys_clk) begin
        if (rst) begin
            prevFlow_reg  <= 16'h0000;
            prevPower_reg <= 16'h0000;
            havePrev_reg  <= 1'b0;
        end else if (sampleValid) begin
            prevFlow_reg  <= flowSample;
            prevPower_reg <= powerSample;
            havePrev_reg  <= 1'b1;
        end
    end

    // interval counts whole seconds only; flow magnitude never steers it
    always @(posedge sys_clk) begin
        if (rst) begin
            intCnt_reg     <= 7'h00;
            interval_reg   <= `MC_ADAPT_MAX_S;
            integrate_reg  <= 1'b0;
            changeSeen_reg <= 1'b0;
        end else begin
            integrate_reg <= intervalEnd;
            if (intervalEnd)
                intCnt_reg <= 7'h00;
            else if (secTick)
                intCnt_reg <= intCnt_reg + 7'h01;
            case (modeSel)
                2'd1: begin
                    if (changeNow) begin
                        interval_reg   <= `MC_ADAPT_MIN_S;
                        changeSeen_reg <= 1'b1;
                    end else if (intervalEnd) begin
                        changeSeen_reg <= 1'b0;
                        if (!changeSeen_reg && interval_reg < `MC_ADAPT_MAX_S)
                            interval_reg <= {interval_reg[5:0], 1'b0};
                        else if (!changeSeen_reg)
                            interval_reg <= `MC_ADAPT_MAX_S;
                    end
                end
                2'd3: interval_reg <= `MC_FAST_S;
                default: interval_reg <= `MC_NORMAL_S;
            endcase
            if (!adaptive)
                changeSeen_reg <= 1'b0;
        end
    end

    assign integrateStrobe = integrate_reg;

    // ****************************************
    // display power-down and heartbeat
    // ****************************************
    wire       displayOffMode = modeCode_reg[2] && (modeSel != 2'd0);
    reg [8:0]  dispCnt_reg;
    reg [4:0]  hbCnt_reg;
    reg        dot_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            dispCnt_reg   <= 9'h000;
            displayOn_reg <= 1'b1;
            hbCnt_reg     <= 5'h00;
            dot_reg       <= 1'b0;
        end else begin
            if (keyPress)
                dispCnt_reg <= 9'h000;
            else if (secTick && dispCnt_reg < DISP_OFF_S)
                dispCnt_reg <= dispCnt_reg + 9'h001;
            displayOn_reg <= !displayOffMode || keyPress || (dispCnt_reg < DISP_OFF_S);
            if (displayOn_reg) begin
                hbCnt_reg <= 5'h00;
                dot_reg   <= 1'b0;
            end else if (secTick) begin
                // dot lit for one second in every thirty
                hbCnt_reg <= (hbCnt_reg == `MC_HEARTBEAT_S - 1) ? 5'h00 : hbCnt_reg + 5'h01;
                dot_reg   <= (hbCnt_reg == `MC_HEARTBEAT_S - 1);
            end
        end
    end

    assign displayOn    = displayOn_reg;
    assign heartbeatDot = dot_reg;

    // ****************************************
    // cold water leak watch
    // ****************************************
    wire       leakPulse = leakOnB_reg ? pulseInB : pulseInA;
    wire [7:0] subLen = leakSubMinutes(leakCode_reg);
    wire [10:0] subsQuot = LEAK_WIN_MIN / subLen;
    wire [5:0] subsNeeded = subsQuot[5:0];
    reg [7:0]  subCnt_reg;
    reg        seen_reg;
    reg        firstPart_reg;
    // first part gets a spare minute, the minute grid runs free of the watch
    wire       subEnd = minTick && (subCnt_reg + 8'h01 >= subLen + {7'h00, firstPart_reg});

    always @(posedge sys_clk) begin
        if (rst || leakCode_reg == 2'd0) begin
            subCnt_reg <= 8'h00;
            seen_reg   <= 1'b0;
            streak_reg <= 6'h00;
            leak_reg   <= 1'b0;
            firstPart_reg <= 1'b1;
        end else begin
            if (subEnd) begin
                subCnt_reg    <= 8'h00;
                firstPart_reg <= 1'b0;
            end else if (minTick)
                subCnt_reg <= subCnt_reg + 8'h01;
            // a pulse on the closing cycle still counts for the closing part
            seen_reg <= subEnd ? 1'b0 : (seen_reg || leakPulse);
            if (subEnd) begin
                if (seen_reg || leakPulse) begin
                    if (streak_reg < subsNeeded)
                        streak_reg <= streak_reg + 6'h01;
                    if (streak_reg + 6'h01 >= subsNeeded)
                        leak_reg <= 1'b1;
                end else begin
                    streak_reg <= 6'h00;
                    leak_reg   <= 1'b0;
                end
            end
        end
    end

    assign leakAlarm = leak_reg;

    // ****************************************
    // display-digit prescalers
    // ****************************************
    wire [2:0] incIn = {volumeInc, coolingEnergyInc, heatEnergyInc};
    wire [2:0] advance;
    wire [9:0] resDiv = (resCode_reg == 2'd0) ? 10'd1 :
                        (resCode_reg == 2'd1) ? 10'd10 :
                        (resCode_reg == 2'd2) ? 10'd100 : 10'd1000;

    genvar s;
    generate
        for (s = 0; s < 3; s = s + 1) begin : g_pre
            reg [9:0] preCnt_reg;
            reg       adv_reg;
            always @(posedge sys_clk) begin
                if (rst) begin
                    preCnt_reg <= 10'h000;
                    adv_reg    <= 1'b0;
                end else begin
                    adv_reg <= incIn[s] && (preCnt_reg + 10'h001 >= resDiv);
                    if (incIn[s])
                        preCnt_reg <= (preCnt_reg + 10'h001 >= resDiv) ? 10'h000
                                      : preCnt_reg + 10'h001;
                end
            end
            assign advance[s] = adv_reg;
        end
    endgenerate

    // ****************************************
    // pulse outputs
    // ****************************************
    wire [31:0] widthCycles = pulseCycles(pulseWidthCode_reg);
    wire [1:0]  pulseOut;

    genvar o;
    generate
        for (o = 0; o < 2; o = o + 1) begin : g_out
            // source is a build-time constant, not reachable from software
            localparam [1:0] SRC = routeSource(METER_TYPE, o);
            reg [7:0]  pending_reg;
            reg [31:0] phase_reg;
            reg [1:0]  state_reg;
            reg        out_reg;
            wire       take = (state_reg == PG_IDLE) && (pending_reg != 8'h00);
            always @(posedge sys_clk) begin
                if (rst) begin
                    pending_reg <= 8'h00;
                    phase_reg   <= 32'h0000_0000;
                    state_reg   <= PG_IDLE;
                    out_reg     <= 1'b0;
                end else begin
                    // queue up to 255 advances so none are lost while a pulse is running; further advances are dropped
                    if (advance[SRC] && !take && pending_reg != 8'hFF)
                        pending_reg <= pending_reg + 8'h01;
                    else if (!advance[SRC] && take)
                        pending_reg <= pending_reg - 8'h01;
                    case (state_reg)
                        PG_IDLE: begin
                            if (take) begin
                                state_reg <= PG_HIGH;
                                out_reg   <= 1'b1;
                                phase_reg <= 32'h0000_0001;
                            end
                        end
                        PG_HIGH: begin
                            if (phase_reg >= widthCycles) begin
                                state_reg <= PG_GAP;
                                out_reg   <= 1'b0;
                                phase_reg <= 32'h0000_0001;
                            end else
                                phase_reg <= phase_reg + 32'h0000_0001;
                        end
                        PG_GAP: begin
                            if (phase_reg >= widthCycles)
                                state_reg <= PG_IDLE;
                            else
                                phase_reg <= phase_reg + 32'h0000_0001;
                        end
                        default: begin
                            state_reg <= PG_IDLE;
                            out_reg   <= 1'b0;
                        end
                    endcase
                end
            end
            assign pulseOut[o] = out_reg;
        end
    endgenerate

    assign pulseOutC = pulseOut[0];
    assign pulseOutD = pulseOut[1];

endmodule

// *** verif/meter_ctrl_asserts.sv ***
`timescale 1ns/1ns
// ********
// port rules
// ********
module meter_ctrl_asserts #(
    parameter int CLKS_PER_SEC = 2,
    parameter int CLKS_PER_MS  = 2
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        regRdStrobe,
    input wire logic [31:0] regRdData,
    input wire logic        keyPress,
    input wire logic        integrateStrobe,
    input wire logic        displayOn,
    input wire logic        heartbeatDot,
    input wire logic        leakAlarm,
    input wire logic        pulseOutC,
    input wire logic        pulseOutD
);
    int     gap;
    int     keyAge;
    int     dotLen;
    int     cLen;
    int     dLen;
    longint upTime;
    logic   seenStrobe;

    always @(posedge sys_clk) begin
        if (rst) begin
            gap <= 0;
            keyAge <= 0;
            dotLen <= 0;
            cLen <= 0;
            dLen <= 0;
            upTime <= 0;
            seenStrobe <= 1'b0;
        end else begin
            gap <= integrateStrobe ? 1 : gap + 1;
            keyAge <= keyPress ? 0 : keyAge + 1;
            dotLen <= heartbeatDot ? dotLen + 1 : 0;
            cLen <= pulseOutC ? cLen + 1 : 0;
            dLen <= pulseOutD ? dLen + 1 : 0;
            upTime <= upTime + 1;
            seenStrobe <= seenStrobe | integrateStrobe;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_rd_slot: assert property (regRdData != 32'h0000_0000 |-> $past(regRdStrobe))
        else $error("read data outside its slot");
    chk_strobe_single: assert property (integrateStrobe |=> !integrateStrobe)
        else $error("accumulate strobe longer than one cycle");
    chk_strobe_grid: assert property (integrateStrobe && seenStrobe |-> gap % CLKS_PER_SEC == 0)
        else $error("accumulate strobe off the second grid");
    chk_key_wake: assert property (keyPress |=> displayOn)
        else $error("key did not wake display");
    chk_disp_timeout: assert property ($fell(displayOn) |-> keyAge >= 479 * CLKS_PER_SEC)
        else $error("display blanked too early");
    chk_dot_dark: assert property ($rose(heartbeatDot) |-> !displayOn)
        else $error("dot shown while display on");
    chk_dot_width: assert property ($fell(heartbeatDot) && !displayOn |-> dotLen == CLKS_PER_SEC)
        else $error("dot width wrong");
    chk_pulse_c_width: assert property ($fell(pulseOutC) |->
        cLen == 32 * CLKS_PER_MS || cLen == 100 * CLKS_PER_MS)
        else $error("output C pulse width wrong");
    chk_pulse_d_width: assert property ($fell(pulseOutD) |->
        dLen == 32 * CLKS_PER_MS || dLen == 100 * CLKS_PER_MS)
        else $error("output D pulse width wrong");
    chk_leak_late: assert property ($rose(leakAlarm) |-> upTime >= 64'd86400 * CLKS_PER_SEC)
        else $error("leak flag before a full day");
endmodule

bind meter_integration_leak_pulse_ctrl meter_ctrl_asserts #(
    .CLKS_PER_SEC(CLKS_PER_SEC),
    .CLKS_PER_MS (CLKS_PER_MS)
) watch (
    .sys_clk(sys_clk), .rst(rst), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .keyPress(keyPress), .integrateStrobe(integrateStrobe), .displayOn(displayOn),
    .heartbeatDot(heartbeatDot), .leakAlarm(leakAlarm), .pulseOutC(pulseOutC),
    .pulseOutD(pulseOutD)
);

// *** verif/meter_pulse_partner.sv ***
`timescale 1ns/1ns
// ********
// meter pulse source and pulse counter
// ********
module meter_pulse_partner (
    input  wire logic        sys_clk,
    input  wire logic [1:0]  emitReq,
    input  wire logic        pulseOutC,
    input  wire logic        pulseOutD,
    output logic             pulseInA,
    output logic             pulseInB,
    output logic [15:0]      countC,
    output logic [15:0]      countD,
    output logic [15:0]      widthC,
    output logic [15:0]      widthD
);
    logic [15:0] runC = 16'h0000;
    logic [15:0] runD = 16'h0000;

    initial begin
        {pulseInA, pulseInB} = 2'b00;
        {countC, countD, widthC, widthD} = 64'h0;
    end

    always @(posedge sys_clk) begin
        pulseInA <= emitReq[0];
        pulseInB <= emitReq[1];
        runC <= pulseOutC ? runC + 16'h0001 : 16'h0000;
        runD <= pulseOutD ? runD + 16'h0001 : 16'h0000;
        if (pulseOutC && runC == 16'h0000) countC <= countC + 16'h0001;
        if (pulseOutD && runD == 16'h0000) countD <= countD + 16'h0001;
        if (!pulseOutC && runC != 16'h0000) widthC <= runC;
        if (!pulseOutD && runD != 16'h0000) widthD <= runD;
    end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
    localparam int CPS = 2;
    localparam int CPM = 2;
    logic        sys_clk = 0;
    logic        rst = 1;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic        regWrStrobe = 0;
    logic        regRdStrobe = 0;
    wire  [31:0] regRdData;
    logic        keyPress = 0;
    logic        sampleValid = 0;
    logic [15:0] flowSample = 16'h0;
    logic [15:0] powerSample = 16'h0;
    logic        heatEnergyInc = 0;
    logic        coolingEnergyInc = 0;
    logic        volumeInc = 0;
    logic [1:0]  emitReq = 2'b00;
    wire         pulseInA, pulseInB, integrateStrobe, displayOn;
    wire         heartbeatDot, leakAlarm, pulseOutC, pulseOutD;
    wire  [15:0] countC, countD, widthC, widthD;
    int          n_errors = 0;
    int          checks = 0;
    int          gap;
    int          n;

    always #5 sys_clk = ~sys_clk;

    meter_integration_leak_pulse_ctrl #(.CLKS_PER_SEC(CPS), .CLKS_PER_MS(CPM)) DUT (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .keyPress(keyPress), .sampleValid(sampleValid), .flowSample(flowSample),
        .powerSample(powerSample), .pulseInA(pulseInA), .pulseInB(pulseInB),
        .heatEnergyInc(heatEnergyInc), .coolingEnergyInc(coolingEnergyInc),
        .volumeInc(volumeInc), .integrateStrobe(integrateStrobe), .displayOn(displayOn),
        .heartbeatDot(heartbeatDot), .leakAlarm(leakAlarm), .pulseOutC(pulseOutC),
        .pulseOutD(pulseOutD));

    meter_pulse_partner partner (
        .sys_clk(sys_clk), .emitReq(emitReq), .pulseOutC(pulseOutC),
        .pulseOutD(pulseOutD), .pulseInA(pulseInA), .pulseInB(pulseInB),
        .countC(countC), .countD(countD), .widthC(widthC), .widthD(widthD));

    // ********
    // access tasks
    // ********
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge sys_clk);
        regWrStrobe <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] exp,
            input string nm);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge sys_clk);
        regRdStrobe <= 1'b0;
        #1 chk(nm, exp, regRdData & msk);
    endtask

    task next_strobe(output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1 cnt++;
        end while (integrateStrobe !== 1'b1 && cnt < 200);
    endtask

    task sample(input logic [15:0] f, input logic [15:0] p);
        @(posedge sys_clk);
        flowSample <= f;
        powerSample <= p;
        sampleValid <= 1'b1;
        @(posedge sys_clk);
        sampleValid <= 1'b0;
    endtask

    task inc(input int k, input int cnt);
        repeat (cnt) begin
            @(posedge sys_clk);
            heatEnergyInc <= (k == 0);
            coolingEnergyInc <= (k == 1);
            volumeInc <= (k == 2);
            @(posedge sys_clk);
            {heatEnergyInc, coolingEnergyInc, volumeInc} <= 3'b000;
        end
    endtask

    task emit(input logic [1:0] which, input int cnt);
        repeat (cnt) begin
            @(posedge sys_clk);
            emitReq <= which;
            @(posedge sys_clk);
            emitReq <= 2'b00;
            repeat (398) @(posedge sys_clk);
        end
    endtask

    task key();
        @(posedge sys_clk);
        keyPress <= 1'b1;
        @(posedge sys_clk);
        keyPress <= 1'b0;
        #1 chk("display wake", 32'h1, {31'h0, displayOn});
    endtask

    task report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        report_and_stop();
    end

    // ********
    // test sequence
    // ********
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(4'h0, 32'hFFFF_FFFF, 32'h0000_0011, "ctrl reset");
        rd(4'h1, 32'hFFFF_FFFF, 32'h0000_005F, "pulse reset");
        rd(4'h2, 32'hFFFF_FFFF, 32'h0000_0010, "thresh reset");
        rd(4'h3, 32'hFFFF_FFFF, 32'h0000_0140, "status reset");
        rd(4'h9, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        wr(4'h3, 32'hFFFF_FFFF);
        rd(4'h3, 32'hFFFF_FFFF, 32'h0000_0140, "status read only");
        wr(4'h2, 32'h0000_1234);
        rd(4'h2, 32'hFFFF_FFFF, 32'h0000_1234, "thresh rw");
        wr(4'h2, 32'h0000_0010);
        wr(4'h0, 32'h0000_001B);
        rd(4'h0, 32'hFFFF_FFFF, 32'h0000_001B, "ctrl rw");
        $display("test registers done");

        wr(4'h0, 32'h0000_0013);
        next_strobe(gap);
        next_strobe(gap);
        chk("fast gap", 4 * CPS, gap);
        wr(4'h0, 32'h0000_0012);
        next_strobe(gap);
        next_strobe(gap);
        chk("normal gap", 32 * CPS, gap);
        wr(4'h0, 32'h0000_0011);
        sample(16'h0000, 16'h0000);
        sample(16'h0100, 16'h0000);
        rd(4'h3, 32'h0000_007F, 32'h0000_0004, "change interval");
        next_strobe(gap);
        for (int k = 0; k < 3; k++) begin
            next_strobe(gap);
            chk("adaptive gap", (8 << k) * CPS, gap);
        end
        rd(4'h3, 32'h0000_007F, 32'h0000_0040, "stable interval");
        sample(16'h0110, 16'h0000);
        rd(4'h3, 32'h0000_007F, 32'h0000_0040, "small change");
        sample(16'h0110, 16'h0200);
        rd(4'h3, 32'h0000_007F, 32'h0000_0004, "power change");
        $display("test integration done");

        wr(4'h0, 32'h0000_0017);
        key();
        repeat (479 * CPS - 3) @(posedge sys_clk);
        #1 chk("display held", 32'h1, {31'h0, displayOn});
        repeat (2 * CPS + 4) @(posedge sys_clk);
        #1 chk("display off", 32'h0, {31'h0, displayOn});
        n = 0;
        while (heartbeatDot !== 1'b1 && n < 31 * CPS + 6) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("dot seen", 32'h1, {31'h0, heartbeatDot});
        n = 0;
        while (heartbeatDot === 1'b1 && n < 50) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("dot width", CPS, n);
        key();
        wr(4'h0, 32'h0000_0013);
        $display("test display done");

        wr(4'h1, 32'h0000_015F);
        inc(0, 10);
        repeat (80) @(posedge sys_clk);
        chk("heat to C", 32'h1, {16'h0, countC});
        chk("C width", 32 * CPM, {16'h0, widthC});
        inc(2, 9);
        repeat (80) @(posedge sys_clk);
        chk("D early", 32'h0, {16'h0, countD});
        inc(2, 1);
        inc(1, 10);
        repeat (80) @(posedge sys_clk);
        chk("volume to D", 32'h1, {16'h0, countD});
        chk("cooling not routed", 32'h1, {16'h0, countC});
        wr(4'h1, 32'h0000_0160);
        inc(0, 10);
        repeat (220) @(posedge sys_clk);
        chk("long width", 100 * CPM, {16'h0, widthC});
        wr(4'h1, 32'h0000_005F);
        inc(0, 3);
        repeat (400) @(posedge sys_clk);
        chk("queued pulses", 32'h5, {16'h0, countC});
        $display("test pulse outputs done");

        wr(4'h0, 32'h0000_0003);
        rd(4'h3, 32'h0000_FC00, 32'h0000_0000, "leak off");
        wr(4'h0, 32'h0000_000B);
        emit(2'b01, 31);
        rd(4'h3, 32'h0000_FC00, 32'h0000_0C00, "streak");
        chk("no early leak", 32'h0, {31'h0, leakAlarm});
        emit(2'b10, 15);
        rd(4'h3, 32'h0000_FC00, 32'h0000_0000, "streak cleared");
        $display("test leak done");
        report_and_stop();
    end
endmodule
